// ### mcr_clock_ctrl.sv
// main clock controller: core clock prescaler, clock out, time base, tone
// assumes clk_i is the oscillator clock, cpu-side inputs share that clock
//
// Design decision made here: the Wishbone register port.
`include "mcr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module mcr_clock_ctrl #(
  parameter int BASE_P0  = `MCR_BASE_P0,
  parameter int BASE_P1  = `MCR_BASE_P1,
  parameter int BASE_P2  = `MCR_BASE_P2,
  parameter int BASE_P3  = `MCR_BASE_P3,
  parameter int TONE_H1  = `MCR_HALF(`MCR_TONE_HZ1),
  parameter int TONE_H2  = `MCR_HALF(`MCR_TONE_HZ2),
  parameter int TONE_H3  = `MCR_HALF(`MCR_TONE_HZ3)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        halt_req_i,
  input  wire logic        wait_req_i,
  input  wire logic        wake_ext_i,
  output logic             core_clk_en_o,
  output logic             clock_out_o,
  output logic             clock_out_oe_n_o,
  output logic             tone_o,
  output logic             tone_oe_n_o,
  output logic             irq_o,
  output logic      [3:0]  pwr_mode_o
);
  mcr_pkg::mcr_pwr_e st;
  mcr_pkg::mcr_pwr_e next_st;
  logic        clk_out_sel;
  logic [1:0]  slow_div;
  logic        slow_mode;
  logic [1:0]  period_sel;
  logic        tick_ie;
  logic        tick_flag;
  logic [1:0]  tone_sel;
  logic        ists;
  logic        imsk;
  logic [5:0]  idx;
  logic        acc;
  logic        wr;
  logic        rd_csr;
  logic        halted;
  logic        frozen;
  logic [7:0]  csr_val;
  logic [17:0] base_next_lim;
  logic [12:0] tone_lim;

  mcr_div_if #(.W(18)) base_div ();
  mcr_div_if #(.W(5))  sp_div ();
  mcr_div_if #(.W(13)) tn_div ();

  mcr_rate_div u_base (.clk_i(clk_i), .rst_i(rst_i), .div(base_div.cnt));
  mcr_rate_div u_sp (.clk_i(clk_i), .rst_i(rst_i), .div(sp_div.cnt));
  mcr_rate_div u_tn (.clk_i(clk_i), .rst_i(rst_i), .div(tn_div.cnt));

  // bus decode, one access per request
  assign idx    = adr_i[7:2];
  assign acc    = cyc_i && stb_i && !ack_o;
  assign halted = (st == mcr_pkg::mcr_halt);
  assign frozen = halted || (st == mcr_pkg::mcr_ahalt);
  assign wr     = acc && we_i && sel_i[0] && !frozen;
  assign rd_csr = acc && !we_i && (idx == `MCR_IDX_CSR);
  assign csr_val = {clk_out_sel, slow_div, slow_mode, period_sel, tick_ie, tick_flag};
  assign pwr_mode_o = st;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= acc;
    end
  end

  // read data, unmapped and foreign indices read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (acc && !we_i) begin
      case (idx)
        `MCR_IDX_CSR:  dat_o <= {24'h00_0000, csr_val};
        `MCR_IDX_TONE: dat_o <= {30'h0000_0000, tone_sel};
        `MCR_IDX_ISTS: dat_o <= {31'h0000_0000, ists};
        `MCR_IDX_IMSK: dat_o <= {31'h0000_0000, imsk};
        default:       dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // control fields written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {clk_out_sel, slow_div, slow_mode, period_sel, tick_ie} <= 7'(`MCR_CSR_RST >> 1);
    end else if (wr && idx == `MCR_IDX_CSR) begin
      clk_out_sel <= dat_i[`MCR_CSR_CKO];
      slow_div    <= dat_i[`MCR_CSR_DIV_H:`MCR_CSR_DIV_L];
      slow_mode   <= dat_i[`MCR_CSR_SLOW];
      period_sel  <= dat_i[`MCR_CSR_PER_H:`MCR_CSR_PER_L];
      tick_ie     <= dat_i[`MCR_CSR_TIE];
    end
  end

  // tone select, upper bits are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tone_sel <= `MCR_TONE_RST;
    end else if (wr && idx == `MCR_IDX_TONE) begin
      tone_sel <= dat_i[`MCR_TONE_H:`MCR_TONE_L];
    end
  end

  // tick flag: set by each period, cleared by a read, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_flag <= 1'b0;
    end else if (base_div.tick) begin
      tick_flag <= 1'b1;
    end else if (rd_csr) begin
      tick_flag <= 1'b0;
    end
  end

  // sticky event status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ists <= 1'b0;
    end else if (base_div.tick) begin
      ists <= 1'b1;
    end else if (wr && idx == `MCR_IDX_ISTS && dat_i[`MCR_EVT_TICK]) begin
      ists <= 1'b0;
    end
  end

  // event mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imsk <= 1'b0;
    end else if (wr && idx == `MCR_IDX_IMSK) begin
      imsk <= dat_i[`MCR_EVT_TICK];
    end
  end

  // interrupt request gated by the tick enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= tick_ie && ists && imsk;
    end
  end

  // period table
  always_comb begin
    case (period_sel)
      2'h0:    base_next_lim = 18'(BASE_P0);
      2'h1:    base_next_lim = 18'(BASE_P1);
      2'h2:    base_next_lim = 18'(BASE_P2);
      default: base_next_lim = 18'(BASE_P3);
    endcase
  end

  // period in use changes only at the end of a period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_div.limit <= 18'(BASE_P0);
    end else if (base_div.tick) begin
      base_div.limit <= base_next_lim;
    end
  end

  // time base runs except in full halt
  assign base_div.en  = !halted;
  assign base_div.clr = 1'b0;

  // slow prescaler, ratio 2 << code, restarted on a control write
  assign sp_div.limit = 5'h02 << slow_div;
  assign sp_div.en    = !frozen;
  assign sp_div.clr   = wr && (idx == `MCR_IDX_CSR);

  // core clock enable, stopped in both halt modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_clk_en_o <= 1'b0;
    end else begin
      core_clk_en_o <= !frozen && (!slow_mode || sp_div.tick);
    end
  end

  // clock out pin, half the core rate, held low in timed halt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_out_o <= 1'b0;
    end else if (!clk_out_sel || frozen) begin
      clock_out_o <= 1'b0;
    end else if (core_clk_en_o) begin
      clock_out_o <= !clock_out_o;
    end
  end

  // clock out pin drive enable follows the select bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_out_oe_n_o <= 1'b1;
    end else begin
      clock_out_oe_n_o <= !clk_out_sel;
    end
  end

  // tone half-period table
  always_comb begin
    case (tone_sel)
      2'h1:    tone_lim = 13'(TONE_H1);
      2'h2:    tone_lim = 13'(TONE_H2);
      default: tone_lim = 13'(TONE_H3);
    endcase
  end

  assign tn_div.limit = tone_lim;
  assign tn_div.en    = !halted && (tone_sel != 2'h0);
  assign tn_div.clr   = wr && (idx == `MCR_IDX_TONE);

  // tone pin toggles each half period, square wave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tone_o      <= 1'b0;
      tone_oe_n_o <= 1'b1;
    end else begin
      tone_oe_n_o <= (tone_sel == 2'h0);
      if (tone_sel == 2'h0) begin
        tone_o <= 1'b0;
      end else if (tn_div.tick) begin
        tone_o <= !tone_o;
      end
    end
  end

  // power mode sequencing
  always_comb begin
    next_st = st;
    case (st)
      mcr_pkg::mcr_run: begin
        if (halt_req_i) begin
          next_st = tick_ie ? mcr_pkg::mcr_ahalt : mcr_pkg::mcr_halt;
        end else if (wait_req_i) begin
          next_st = mcr_pkg::mcr_wait;
        end
      end
      mcr_pkg::mcr_wait: begin
        if (irq_o || wake_ext_i) begin
          next_st = mcr_pkg::mcr_run;
        end
      end
      mcr_pkg::mcr_ahalt: begin
        if (irq_o || wake_ext_i) begin
          next_st = mcr_pkg::mcr_run;
        end
      end
      mcr_pkg::mcr_halt: begin
        if (wake_ext_i) begin
          next_st = mcr_pkg::mcr_run;
        end
      end
      default: next_st = mcr_pkg::mcr_run;
    endcase
  end

  // power mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= mcr_pkg::mcr_run;
    end else begin
      st <= next_st;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ahalt_cmd;
    st == mcr_pkg::mcr_run && halt_req_i && tick_ie;
  endsequence
  sequence s_halt_cmd;
    st == mcr_pkg::mcr_run && halt_req_i && !tick_ie;
  endsequence

  property p_clkout_oe;
    clk_out_sel |=> !clock_out_oe_n_o;
  endproperty
  a_clkout_oe: assert property (p_clkout_oe)
    else $error("clock out pin not driven while selected");

  property p_clkout_idle;
    (st == mcr_pkg::mcr_ahalt) [*2] |-> !clock_out_o;
  endproperty
  a_clkout_idle: assert property (p_clkout_idle)
    else $error("clock out active in timed halt");

  property p_core_full;
    (st == mcr_pkg::mcr_run && !slow_mode) |=> core_clk_en_o;
  endproperty
  a_core_full: assert property (p_core_full)
    else $error("core clock missing in normal mode");

  property p_irq_gate;
    !tick_ie |=> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");

  property p_enter_ahalt;
    s_ahalt_cmd |=> st == mcr_pkg::mcr_ahalt;
  endproperty
  a_enter_ahalt: assert property (p_enter_ahalt)
    else $error("halt with tick enable missed timed halt");

  property p_enter_halt;
    s_halt_cmd |=> st == mcr_pkg::mcr_halt;
  endproperty
  a_enter_halt: assert property (p_enter_halt)
    else $error("halt without tick enable missed full halt");

  property p_wake_ahalt;
    (st == mcr_pkg::mcr_ahalt && irq_o) |=> st == mcr_pkg::mcr_run;
  endproperty
  a_wake_ahalt: assert property (p_wake_ahalt)
    else $error("tick interrupt did not end timed halt");

  property p_flag_set;
    base_div.tick |=> tick_flag && ists;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("tick flag not set at period end");

  property p_flag_clr;
    (rd_csr && !base_div.tick) |=> !tick_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("tick flag survived a read");

  property p_period_hold;
    !base_div.tick |=> $stable(base_div.limit);
  endproperty
  a_period_hold: assert property (p_period_hold)
    else $error("period changed inside a period");

  property p_halt_hold;
    (st == mcr_pkg::mcr_halt && !wake_ext_i) |=> st == mcr_pkg::mcr_halt && !base_div.tick;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("full halt left without external wake");

  property p_tone_off;
    (tone_sel == 2'h0) [*2] |-> !tone_o && tone_oe_n_o;
  endproperty
  a_tone_off: assert property (p_tone_off)
    else $error("tone pin active while off");
endmodule
`default_nettype wire

// ### mcr_cfg.svh
// offsets, field positions, reset values and timing counts of the clock controller
// assumes a 32-bit classic Wishbone bus with word-aligned registers
// Contract
// - clock_out_select drives core clock on pin
// - clock output idle during timed halt
// - slow divider codes give /2 /4 /8 /16
// - slow mode selects divided core clock
// - period codes give 16000 to 200000 cycles
// - new period applies after current period ends
// - tick interrupt requested only while enabled
// - halt with tick enable enters timed halt
// - tick interrupt wakes from timed halt
// - flag set at each completed period
// - reading control register clears the flag
// - tone select gives off, 2k, 1k, 500 Hz
// - tone keeps running in timed halt
// - full halt freezes counter and registers
// - tick wakes wait and timed halt only
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// register indices, byte address is four times the index
`define MCR_IDX_SIS   6'h2B
`define MCR_IDX_CSR   6'h2C
`define MCR_IDX_TONE  6'h2D
`define MCR_IDX_ISTS  6'h30
`define MCR_IDX_IMSK  6'h31

// control/status fields
`define MCR_CSR_CKO   7
`define MCR_CSR_DIV_H 6
`define MCR_CSR_DIV_L 5
`define MCR_CSR_SLOW  4
`define MCR_CSR_PER_H 3
`define MCR_CSR_PER_L 2
`define MCR_CSR_TIE   1
`define MCR_CSR_TFL   0
`define MCR_TONE_H    1
`define MCR_TONE_L    0
`define MCR_EVT_TICK  0

// reset values
`define MCR_CSR_RST   8'h00
`define MCR_TONE_RST  2'h0

// time-base periods in oscillator cycles
`define MCR_BASE_P0   16000
`define MCR_BASE_P1   32000
`define MCR_BASE_P2   80000
`define MCR_BASE_P3   200000

// tone frequencies in Hz at the reference oscillator rate
`define MCR_REF_HZ    8000000
`define MCR_TONE_HZ1  2000
`define MCR_TONE_HZ2  1000
`define MCR_TONE_HZ3  500
`define MCR_HALF(hz)  (`MCR_REF_HZ / (2 * (hz)))

`endif

// ### mcr_pkg.sv
// types shared by the clock controller modules
// assumes nothing of its surroundings
package mcr_pkg;
  // power modes, one-hot
  typedef enum logic [3:0] {
    mcr_run   = 4'h1,
    mcr_wait  = 4'h2,
    mcr_ahalt = 4'h4,
    mcr_halt  = 4'h8
  } mcr_pwr_e;
endpackage

// ### mcr_div_if.sv
// interface between the controller and one rate divider
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface mcr_div_if #(parameter int W = 4);
  logic         en;
  logic         clr;
  logic [W-1:0] limit;
  logic         tick;
  modport ctrl (output en, output clr, output limit, input tick);
  modport cnt  (input en, input clr, input limit, output tick);
endinterface
`default_nettype wire

// ### mcr_rate_div.sv
// rate divider: counts enabled cycles and pulses tick every limit cycles
// assumes limit is at least one and stable except where the caller allows
`timescale 1ns/10ps
`default_nettype none
module mcr_rate_div (
  input  wire logic clk_i,
  input  wire logic rst_i,
  mcr_div_if.cnt    div
);
  localparam int W = $bits(div.limit);
  logic [W-1:0] cnt;
  logic         last;

  // end of period reached
  assign last = (cnt >= div.limit - 1'b1);

  // counter restarts at zero after each period
  always_ff @(posedge clk_i) begin
    if (rst_i || div.clr) begin
      cnt <= '0;
    end else if (div.en) begin
      if (last) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  assign div.tick = div.en && !div.clr && last;
endmodule
`default_nettype wire

// ### mcr_clock_ctrl_tb_top.sv
// directed testbench of the clock controller: bus tasks, pin counters, checks
// assumes mcr_cfg.svh, the interface and the design modules compiled first
`include "mcr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module mcr_clock_ctrl_tb_top;
  localparam int TBP [4] = '{20, 30, 40, 50};
  localparam int TNH [4] = '{0, 4, 6, 8};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [2:0]  req   = 3'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        core_clk_en_o;
  logic        clock_out_o;
  logic        clock_out_oe_n_o;
  logic        tone_o;
  logic        tone_oe_n_o;
  logic        irq_o;
  logic [3:0]  pwr_mode_o;
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          cyc_cnt    = 0;
  logic [31:0] rd;
  int          c;
  int          t0;
  int          t1;
  int          t2;

  // short periods keep the run brief
  mcr_clock_ctrl #(.BASE_P0(TBP[0]), .BASE_P1(TBP[1]), .BASE_P2(TBP[2]), .BASE_P3(TBP[3]),
    .TONE_H1(TNH[1]), .TONE_H2(TNH[2]), .TONE_H3(TNH[3])) u_mcr_clock_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .halt_req_i(req[0]), .wait_req_i(req[1]), .wake_ext_i(req[2]),
    .core_clk_en_o(core_clk_en_o), .clock_out_o(clock_out_o),
    .clock_out_oe_n_o(clock_out_oe_n_o), .tone_o(tone_o), .tone_oe_n_o(tone_oe_n_o),
    .irq_o(irq_o), .pwr_mode_o(pwr_mode_o));

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // counts and prints the verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // cycle counter and hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // one comparison
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // classic single wishbone cycle, read data left in rd
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    chk("ack_wait", 2, n);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // pin level picked by s: 0 core enable, 1 clock out, 2 tone
  function automatic logic pin(input int s);
    return s == 0 ? core_clk_en_o : (s == 1 ? clock_out_o : tone_o);
  endfunction

  // enable cycles (s 0) or level changes (s 1, 2) over n cycles
  task automatic cnt(input int n, input int s, output int k);
    logic p;
    p = pin(s);
    k = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (s == 0) k += int'(pin(s) === 1'b1);
      else k += int'(pin(s) !== p);
      p = pin(s);
    end
  endtask

  // waits for a fresh interrupt rise and stamps its cycle
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    while (irq_o !== 1'b0 && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    while (irq_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk("irq_rise", 1, irq_o);
    t = cyc_cnt;
  endtask

  // one-cycle pulse on halt, wait or wake request
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i);
    req <= m;
    @(posedge clk_i);
    req <= 3'h0;
    @(posedge clk_i);
  endtask

  // main test sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pwr", 4'h1, pwr_mode_o);
    chk("cko_oe_n", 1, clock_out_oe_n_o);
    chk("tone_oe_n", 1, tone_oe_n_o);
    bus(0, `MCR_IDX_CSR, 8'h00);
    chk("csr", 0, rd & 32'hFE);
    bus(0, `MCR_IDX_TONE, 8'h00);
    chk("tone", 0, rd);
    bus(0, 6'h3F, 8'h00);
    chk("unmapped", 0, rd);
    $display("done: reset");
    cnt(16, 0, c);
    chk("fast_en", 16, c);
    for (int i = 0; i < 4; i++) begin
      bus(1, `MCR_IDX_CSR, 8'(i * 32 + 16));
      repeat (2) @(posedge clk_i);
      cnt(64, 0, c);
      chk("slow_en", 64 >> (i + 1), c);
    end
    bus(1, `MCR_IDX_CSR, 8'h80);
    repeat (2) @(posedge clk_i);
    chk("cko_oe_n", 0, clock_out_oe_n_o);
    cnt(16, 1, c);
    chk("cko_edges", 16, c);
    bus(1, `MCR_IDX_CSR, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("cko_oe_n", 1, clock_out_oe_n_o);
    chk("cko", 0, clock_out_o);
    $display("done: prescaler and clock out");
    bus(1, `MCR_IDX_IMSK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      bus(1, `MCR_IDX_CSR, 8'(i * 4 + 2));
      bus(1, `MCR_IDX_ISTS, 8'h01);
      wait_irq(t0);
      bus(1, `MCR_IDX_ISTS, 8'h01);
      wait_irq(t1);
      bus(1, `MCR_IDX_ISTS, 8'h01);
      wait_irq(t2);
      chk("period", TBP[i], t2 - t1);
    end
    bus(1, `MCR_IDX_ISTS, 8'h01);
    bus(1, `MCR_IDX_CSR, 8'h02);
    wait_irq(t0);
    chk("old_period", TBP[3], t0 - t2);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    wait_irq(t1);
    chk("new_period", TBP[0], t1 - t0);
    bus(0, `MCR_IDX_CSR, 8'h00);
    chk("csr_flag", 8'h03, rd);
    bus(0, `MCR_IDX_CSR, 8'h00);
    chk("csr_clear", 8'h02, rd);
    $display("done: time base");
    bus(1, `MCR_IDX_CSR, 8'h00);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    c = 0;
    repeat (30) begin
      @(posedge clk_i);
      c += int'(irq_o !== 1'b0);
    end
    chk("irq_off", 0, c);
    bus(0, `MCR_IDX_ISTS, 8'h00);
    chk("status", 1, rd & 32'h1);
    bus(0, `MCR_IDX_CSR, 8'h00);
    chk("flag", 1, rd & 32'h1);
    bus(1, `MCR_IDX_CSR, 8'h02);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    wait_irq(t0);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irq_cleared", 0, irq_o);
    bus(1, `MCR_IDX_IMSK, 8'h00);
    repeat (25) @(posedge clk_i);
    chk("irq_masked", 0, irq_o);
    bus(1, `MCR_IDX_IMSK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irq_unmasked", 1, irq_o);
    $display("done: interrupt");
    for (int i = 1; i < 4; i++) begin
      bus(1, `MCR_IDX_TONE, 8'(i));
      repeat (2) @(posedge clk_i);
      chk("tone_oe_n", 0, tone_oe_n_o);
      cnt(48, 2, c);
      chk("tone_edges", 48 / TNH[i], c);
    end
    bus(0, `MCR_IDX_TONE, 8'h00);
    chk("tone_rd", 3, rd);
    bus(1, `MCR_IDX_TONE, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("tone_oe_n", 1, tone_oe_n_o);
    cnt(16, 2, c);
    chk("tone_off", 0, c);
    $display("done: tone");
    bus(1, `MCR_IDX_TONE, 8'h01);
    bus(1, `MCR_IDX_CSR, 8'h8E);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    wait_irq(t0);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    pulse(3'h1);
    chk("timed_halt", 4'h4, pwr_mode_o);
    // the last run-mode toggle of clock out is still visible here
    @(posedge clk_i);
    cnt(8, 1, c);
    chk("cko_halted", 0, c + int'(clock_out_o));
    cnt(8, 0, c);
    chk("core_stopped", 0, c);
    cnt(8, 2, c);
    chk("tone_in_halt", 8 / TNH[1], c);
    c = 0;
    while (pwr_mode_o !== 4'h1 && c < 80) begin
      @(posedge clk_i);
      c++;
    end
    chk("tick_wake", 4'h1, pwr_mode_o);
    bus(1, `MCR_IDX_CSR, 8'h00);
    pulse(3'h1);
    chk("full_halt", 4'h8, pwr_mode_o);
    cnt(60, 2, c);
    chk("tone_frozen", 0, c);
    chk("still_halt", 4'h8, pwr_mode_o);
    pulse(3'h4);
    chk("ext_wake", 4'h1, pwr_mode_o);
    pulse(3'h2);
    chk("wait", 4'h2, pwr_mode_o);
    pulse(3'h4);
    chk("wait_wake", 4'h1, pwr_mode_o);
    // tick interrupt ends wait mode
    bus(1, `MCR_IDX_CSR, 8'h02);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    wait_irq(t0);
    bus(1, `MCR_IDX_ISTS, 8'h01);
    pulse(3'h2);
    chk("wait_tick", 4'h2, pwr_mode_o);
    wait_irq(t1);
    @(posedge clk_i);
    chk("tick_wait_wake", 4'h1, pwr_mode_o);
    $display("done: power modes");
    give_verdict();
  end
endmodule
`default_nettype wire
